// ===== core/srqe_core.sv
`timescale 1ns/1ps
// Function
// - option reply field one names memory option
// - option reply field two names scanner card
// - recall restores setup from valid slot
// - save stores current setup into slot
// - whole reset-affected setup is saved, restored
// - all slots start at preset defaults
// - recall error reloads slots with preset
// - reset restores defaults, cancels pending, responses
// - mask loaded from binary of written value
// - mask bits map to status summary bits
// - cleared mask bit blocks its request
// - enabled set status bit other than bits 1 and 6 raises request
// - mask clears to zero at power-up
// - enable query returns current mask
// - summary bit set on enabled condition
module srqe_core
    import srqe_pkg::*;
(
    input  wire logic               core_clk,
    input  wire logic               rst_b,
    input  wire logic               cmd_valid,
    input  wire logic [2:0]         cmd_code,
    input  wire logic [7:0]         cmd_arg,
    input  wire logic [1:0]         mem_option,
    input  wire logic               scanner_present,
    input  wire logic [SETUP_W-1:0] cur_setup,
    input  wire logic [7:0]         status_byte,
    input  wire logic               mem_fault,
    output logic                    cmd_ready,
    output logic                    rsp_valid,
    output logic      [7:0]         rsp_field0,
    output logic      [7:0]         rsp_field1,
    output logic                    cmd_rejected,
    output logic                    setup_load,
    output logic      [SETUP_W-1:0] setup_out,
    output logic                    cancel_pending,
    output logic                    drop_opc,
    output logic                    recall_error,
    output logic                    srq,
    output logic                    mss_bit,
    output logic      [7:0]         service_request_mask
);

    // =========================================================
    // reset release
    logic rst_meta;
    logic rst_sync;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // =========================================================
    // state
    typedef struct packed {
        srqe_fsm_type       fsm;
        logic [3:0]         slot;
        logic [7:0]         mask;
        logic               cmd_ready;
        logic               rsp_valid;
        logic [7:0]         rsp_field0;
        logic [7:0]         rsp_field1;
        logic               cmd_rejected;
        logic               setup_load;
        logic [SETUP_W-1:0] setup_out;
        logic               cancel_pending;
        logic               drop_opc;
        logic               recall_error;
        logic               srq;
        logic               mss_bit;
        logic               wr_en;
        logic               clr_all;
        logic [3:0]         wr_addr;
        logic [SETUP_W-1:0] wr_data;
    } srqe_state_type;

    srqe_state_type     s;
    srqe_state_type     next_s;
    logic [SETUP_W-1:0] rd_data;
    logic               rd_par_ok;
    logic               take;
    logic [3:0]         slot_max;
    logic               slot_ok;
    logic               enabled_hit;

    srqe_slots srqe_slots_inst (
        .core_clk  (core_clk),
        .rst_b     (rst_sync),
        .wr_en     (s.wr_en),
        .wr_addr   (s.wr_addr),
        .wr_data   (s.wr_data),
        .clr_all   (s.clr_all),
        .rd_addr   (s.slot),
        .rd_data   (rd_data),
        .rd_par_ok (rd_par_ok)
    );

    // =========================================================
    // command decode
    assign take = cmd_valid && s.cmd_ready;

    always_comb begin
        case (mem_option)
            MEM_OPT1: slot_max = SLOT_MAX_OPT1;
            MEM_OPT2: slot_max = SLOT_MAX_OPT2;
            default:  slot_max = SLOT_MAX_BASE;
        endcase
    end

    assign slot_ok     = cmd_arg <= {4'h0, slot_max};
    // bit 6 is the summary itself and bit 1 is unused, so neither may feed back
    assign enabled_hit = |(status_byte & s.mask & SRE_USED);

    always_comb begin
        next_s                = s;
        next_s.rsp_valid      = 1'b0;
        next_s.cmd_rejected   = 1'b0;
        next_s.setup_load     = 1'b0;
        next_s.cancel_pending = 1'b0;
        next_s.drop_opc       = 1'b0;
        next_s.recall_error   = 1'b0;
        next_s.wr_en          = 1'b0;
        next_s.clr_all        = 1'b0;
        next_s.srq            = enabled_hit;
        next_s.mss_bit        = enabled_hit;
        case (s.fsm)
            ST_IDLE: begin
                if (take) begin
                    case (cmd_code)
                        CMD_OPT: begin
                            next_s.rsp_valid  = 1'b1;
                            case (mem_option)
                                MEM_OPT1: next_s.rsp_field0 = OPT_MEM1_CODE;
                                MEM_OPT2: next_s.rsp_field0 = OPT_MEM2_CODE;
                                default:  next_s.rsp_field0 = OPT_NONE;
                            endcase
                            next_s.rsp_field1 = scanner_present ? OPT_SCAN_CODE : OPT_NONE;
                        end
                        CMD_RCL: begin
                            if (slot_ok) begin
                                next_s.slot      = cmd_arg[3:0];
                                next_s.fsm       = ST_READ;
                                next_s.cmd_ready = 1'b0;
                            end else begin
                                next_s.cmd_rejected = 1'b1;
                            end
                        end
                        CMD_SAV: begin
                            if (slot_ok) begin
                                next_s.wr_en   = 1'b1;
                                next_s.wr_addr = cmd_arg[3:0];
                                next_s.wr_data = cur_setup;
                            end else begin
                                next_s.cmd_rejected = 1'b1;
                            end
                        end
                        CMD_RST: begin
                            next_s.setup_out      = RESET_SETUP;
                            next_s.setup_load     = 1'b1;
                            next_s.cancel_pending = 1'b1;
                            next_s.drop_opc       = 1'b1;
                        end
                        CMD_SRE_WR: begin
                            next_s.mask = cmd_arg;
                        end
                        CMD_SRE_RD: begin
                            next_s.rsp_valid  = 1'b1;
                            next_s.rsp_field0 = s.mask;
                            next_s.rsp_field1 = OPT_NONE;
                        end
                        default: begin
                            next_s.cmd_rejected = 1'b1;
                        end
                    endcase
                end
            end
            ST_READ: begin
                next_s.fsm = ST_CHECK;
            end
            ST_CHECK: begin
                next_s.fsm        = ST_IDLE;
                next_s.cmd_ready  = 1'b1;
                next_s.setup_load = 1'b1;
                if (!rd_par_ok || mem_fault) begin
                    // a bad slot is not trusted; the instrument falls back to preset
                    next_s.clr_all      = 1'b1;
                    next_s.recall_error = 1'b1;
                    next_s.setup_out    = PRESET_SETUP;
                end else begin
                    next_s.setup_out = rd_data;
                end
            end
            default: begin
                next_s.fsm       = ST_IDLE;
                next_s.cmd_ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            s           <= '0;
            s.fsm       <= ST_IDLE;
            s.mask      <= SRE_RESET;
            s.cmd_ready <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // =========================================================
    // outputs
    assign cmd_ready            = s.cmd_ready;
    assign rsp_valid            = s.rsp_valid;
    assign rsp_field0           = s.rsp_field0;
    assign rsp_field1           = s.rsp_field1;
    assign cmd_rejected         = s.cmd_rejected;
    assign setup_load           = s.setup_load;
    assign setup_out            = s.setup_out;
    assign cancel_pending       = s.cancel_pending;
    assign drop_opc             = s.drop_opc;
    assign recall_error         = s.recall_error;
    assign srq                  = s.srq;
    assign mss_bit              = s.mss_bit;
    assign service_request_mask = s.mask;

    // =========================================================
    // checks
    AST_OPT_MEM: assert property (@(posedge core_clk) disable iff (!rst_sync)
        (take && cmd_code == CMD_OPT && mem_option == MEM_BASE) |=> (rsp_valid && rsp_field0 == OPT_NONE))
        else $error("option reply memory field wrong");

    AST_OPT_SCAN: assert property (@(posedge core_clk) disable iff (!rst_sync)
        (take && cmd_code == CMD_OPT) |=> (rsp_field1 == ($past(scanner_present) ? OPT_SCAN_CODE : OPT_NONE)))
        else $error("option reply scanner field wrong");

    AST_RECALL: assert property (@(posedge core_clk) disable iff (!rst_sync)
        (take && cmd_code == CMD_RCL && slot_ok) |=> !cmd_ready ##1 !cmd_ready ##1 (setup_load && cmd_ready))
        else $error("recall did not load setup in three cycles");

    AST_SAVE: assert property (@(posedge core_clk) disable iff (!rst_sync)
        (take && cmd_code == CMD_SAV && slot_ok) |=> (s.wr_en && s.wr_data == $past(cur_setup)))
        else $error("save did not write current setup");

    AST_RCL_ERR: assert property (@(posedge core_clk) disable iff (!rst_sync)
        (s.fsm == ST_CHECK && (!rd_par_ok || mem_fault)) |=> (recall_error && s.clr_all && setup_out == PRESET_SETUP))
        else $error("recall error did not reload presets");

    AST_RST: assert property (@(posedge core_clk) disable iff (!rst_sync)
        (take && cmd_code == CMD_RST) |=> (setup_load && cancel_pending && drop_opc && setup_out == RESET_SETUP))
        else $error("reset command effects missing");

    AST_MASK_LOAD: assert property (@(posedge core_clk) disable iff (!rst_sync)
        (take && cmd_code == CMD_SRE_WR) |=> (service_request_mask == $past(cmd_arg)))
        else $error("enable mask not loaded");

    AST_SRQ_MASKED: assert property (@(posedge core_clk) disable iff (!rst_sync)
        ((status_byte & service_request_mask & SRE_USED) == 8'h00) |=> !srq)
        else $error("request raised by masked bit");

    AST_SRQ_GATE: assert property (@(posedge core_clk) disable iff (!rst_sync)
        (|(status_byte & service_request_mask & SRE_USED)) |=> (srq && mss_bit))
        else $error("enabled status bit raised no request");

    AST_MASK_RESET: assert property (@(posedge core_clk)
        $rose(rst_sync) |-> (service_request_mask == SRE_RESET))
        else $error("mask not clear after reset");

    AST_SRE_READ: assert property (@(posedge core_clk) disable iff (!rst_sync)
        (take && cmd_code == CMD_SRE_RD) |=> (rsp_valid && rsp_field0 == $past(service_request_mask)))
        else $error("enable query returned wrong mask");

    AST_REJECT: assert property (@(posedge core_clk) disable iff (!rst_sync)
        (take && (cmd_code == CMD_RCL || cmd_code == CMD_SAV) && !slot_ok)
            |=> (cmd_rejected && !s.wr_en && cmd_ready) ##1 !setup_load)
        else $error("out of range slot not rejected");

    AST_OPT_MEM2: assert property (@(posedge core_clk) disable iff (!rst_sync)
        (take && cmd_code == CMD_OPT && mem_option == MEM_OPT2) |=> (rsp_valid && rsp_field0 == OPT_MEM2_CODE))
        else $error("option reply second memory code wrong");

    AST_SAVE_ADDR: assert property (@(posedge core_clk) disable iff (!rst_sync)
        (take && cmd_code == CMD_SAV && slot_ok) |=> ({4'h0, s.wr_addr} == $past(cmd_arg)))
        else $error("save went to the wrong slot");

    AST_MASK_HOLD: assert property (@(posedge core_clk) disable iff (!rst_sync)
        !(take && cmd_code == CMD_SRE_WR) |=> $stable(service_request_mask))
        else $error("enable mask changed without a write");

    AST_MSS_MASKED: assert property (@(posedge core_clk) disable iff (!rst_sync)
        ((status_byte & service_request_mask & SRE_USED) == 8'h00) |=> !mss_bit)
        else $error("summary bit set with no enabled condition");

endmodule // srqe_core

// ===== core/srqe_pkg.sv
package srqe_pkg;

    // =========================================================
    // setup and slot memory
    localparam int          SETUP_W       = 16;
    localparam int          SLOTS         = 10;
    localparam logic [15:0] PRESET_SETUP  = 16'h00A5;
    localparam logic [15:0] RESET_SETUP   = 16'h0005;

    // =========================================================
    // installed memory option and highest valid slot
    localparam logic [1:0]  MEM_BASE      = 2'h0;
    localparam logic [1:0]  MEM_OPT1      = 2'h1;
    localparam logic [1:0]  MEM_OPT2      = 2'h2;
    localparam logic [3:0]  SLOT_MAX_BASE = 4'h0;
    localparam logic [3:0]  SLOT_MAX_OPT1 = 4'h4;
    localparam logic [3:0]  SLOT_MAX_OPT2 = 4'h9;

    // =========================================================
    // option query codes; all non-zero values are arbitrary
    localparam logic [7:0]  OPT_NONE      = 8'h00;
    localparam logic [7:0]  OPT_MEM1_CODE = 8'hA1;
    localparam logic [7:0]  OPT_MEM2_CODE = 8'hA2;
    localparam logic [7:0]  OPT_SCAN_CODE = 8'h5C;

    // =========================================================
    // enable mask layout
    localparam int          SRE_MSB_BIT   = 0;
    localparam int          SRE_EAV_BIT   = 2;
    localparam int          SRE_QSB_BIT   = 3;
    localparam int          SRE_MAV_BIT   = 4;
    localparam int          SRE_ESB_BIT   = 5;
    localparam int          SRE_OSB_BIT   = 7;
    localparam logic [7:0]  SRE_USED      = 8'hBD;
    localparam logic [7:0]  SRE_RESET     = 8'h00;

    // =========================================================
    // commands and states
    typedef enum logic [2:0] {
        CMD_OPT    = 3'h0,
        CMD_RCL    = 3'h1,
        CMD_SAV    = 3'h2,
        CMD_RST    = 3'h3,
        CMD_SRE_WR = 3'h4,
        CMD_SRE_RD = 3'h5
    } srqe_cmd_type;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_CHECK = 2'b11
    } srqe_fsm_type;

endpackage

// ===== core/srqe_slots.sv
`timescale 1ns/1ps
module srqe_slots
    import srqe_pkg::*;
(
    input  wire logic               core_clk,
    input  wire logic               rst_b,
    input  wire logic               wr_en,
    input  wire logic [3:0]         wr_addr,
    input  wire logic [SETUP_W-1:0] wr_data,
    input  wire logic               clr_all,
    input  wire logic [3:0]         rd_addr,
    output logic      [SETUP_W-1:0] rd_data,
    output logic                    rd_par_ok
);

    // =========================================================
    // state: slots with an even parity bit on top
    typedef struct packed {
        logic [SLOTS-1:0][SETUP_W:0] slot;
        logic [SETUP_W:0]            rd;
    } srqe_slots_type;

    localparam logic [SETUP_W:0] PRESET_WORD = {^PRESET_SETUP, PRESET_SETUP};

    srqe_slots_type s;
    srqe_slots_type next_s;

    always_comb begin
        next_s = s;
        for (int i = 0; i < SLOTS; i++) begin
            if (clr_all) begin
                next_s.slot[i] = PRESET_WORD;
            end else if (wr_en && wr_addr == 4'(i)) begin
                next_s.slot[i] = {^wr_data, wr_data};
            end
        end
        next_s.rd = (rd_addr < 4'(SLOTS)) ? s.slot[rd_addr] : PRESET_WORD;
    end

    // no other flip-flop needs the preset at reset, so the array takes it directly
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '{slot: {SLOTS{PRESET_WORD}}, rd: PRESET_WORD};
        end else begin
            s <= next_s;
        end
    end

    assign rd_data   = s.rd[SETUP_W-1:0];
    assign rd_par_ok = (^s.rd) == 1'b0;

endmodule // srqe_slots

// ===== sim/srqe_host_model.sv
`timescale 1ns/1ps
module srqe_host_model
    import srqe_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       cmd_ready,
    output logic            cmd_valid,
    output logic [2:0]      cmd_code,
    output logic [7:0]      cmd_arg,
    output logic            wait_fail
);
    // =========================================================
    // command issue
    initial begin
        cmd_valid = 1'b0;
        cmd_code  = 3'h0;
        cmd_arg   = 8'h00;
        wait_fail = 1'b0;
    end

    task automatic issue(input logic [2:0] code, input logic [7:0] arg);
        logic ok;
        int   n;
        @(posedge core_clk);
        cmd_valid <= 1'b1;
        cmd_code  <= code;
        cmd_arg   <= arg;
        n = 0;
        do begin
            @(negedge core_clk);
            ok = cmd_ready;
            @(posedge core_clk);
            n++;
        end while (ok !== 1'b1 && n < 20);
        if (ok !== 1'b1) wait_fail <= 1'b1;
        // released lines flip so a late sample by the device reads wrong
        cmd_valid <= 1'b0;
        cmd_code  <= ~code;
        cmd_arg   <= ~arg;
    endtask

    // mask value is the sum of the weights of the wanted bits
    task automatic write_mask(input logic [7:0] val);
        issue(CMD_SRE_WR, val);
    endtask
endmodule // srqe_host_model

// ===== sim/srqe_core_tb.sv
`timescale 1ns/1ps
module srqe_core_tb
    import srqe_pkg::*;
;
    // =========================================================
    // signals
    logic               core_clk        = 1'b0;
    logic               rst_b           = 1'b0;
    logic [1:0]         mem_option      = 2'h0;
    logic               scanner_present = 1'b0;
    logic [SETUP_W-1:0] cur_setup       = 16'h0000;
    logic [7:0]         status_byte     = 8'h00;
    logic               mem_fault       = 1'b0;
    logic               cmd_valid, cmd_ready, rsp_valid, cmd_rejected, setup_load;
    logic               cancel_pending, drop_opc, recall_error, srq, mss_bit, wait_fail;
    logic [2:0]         cmd_code;
    logic [7:0]         cmd_arg, rsp_field0, rsp_field1, service_request_mask;
    logic [SETUP_W-1:0] setup_out;
    int                 err_total = 0;
    int                 checks    = 0;

    always #25 core_clk = ~core_clk;

    srqe_core srqe_core_inst (
        .core_clk(core_clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_arg(cmd_arg), .mem_option(mem_option), .scanner_present(scanner_present),
        .cur_setup(cur_setup), .status_byte(status_byte), .mem_fault(mem_fault),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_field0(rsp_field0),
        .rsp_field1(rsp_field1), .cmd_rejected(cmd_rejected), .setup_load(setup_load),
        .setup_out(setup_out), .cancel_pending(cancel_pending), .drop_opc(drop_opc),
        .recall_error(recall_error), .srq(srq), .mss_bit(mss_bit),
        .service_request_mask(service_request_mask)
    );

    srqe_host_model srqe_host_model_inst (
        .core_clk(core_clk), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_arg(cmd_arg), .wait_fail(wait_fail)
    );

    // =========================================================
    // helpers
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wait_neg(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // the host returns at the taking edge: n = 1 sees a one-cycle answer, n = 3 a recall load
    task automatic op(input logic [2:0] code, input logic [7:0] arg, input int n);
        srqe_host_model_inst.issue(code, arg);
        wait_neg(n);
    endtask

    task automatic do_reset();
        @(posedge core_clk);
        rst_b <= 1'b0;
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge core_clk);
    endtask

    task automatic print_verdict();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // =========================================================
    // scenarios
    task automatic t_power_up();
        wait_neg(1);
        chk("mask_pon", service_request_mask, SRE_RESET);
        chk("srq_pon", srq, 1'b0);
        srqe_host_model_inst.issue(CMD_RCL, 8'h00);
        wait_neg(1);
        chk("rcl_busy", cmd_ready, 1'b0);
        wait_neg(2);
        chk("rcl_ready", cmd_ready, 1'b1);
        chk("pre_load", setup_load, 1'b1);
        chk("pre_data", setup_out, PRESET_SETUP);
    endtask

    task automatic t_option();
        logic [7:0] m;
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            mem_option      <= i[1:0];
            scanner_present <= i[2];
            m = (i[1:0] == 2'h1) ? OPT_MEM1_CODE : (i[1:0] == 2'h2) ? OPT_MEM2_CODE : OPT_NONE;
            op(CMD_OPT, 8'h00, 1);
            chk("opt_valid", rsp_valid, 1'b1);
            chk("opt_mem", rsp_field0, m);
            chk("opt_scan", rsp_field1, i[2] ? OPT_SCAN_CODE : OPT_NONE);
        end
    endtask

    // top valid slot per option works, one above it is refused
    task automatic t_slots();
        logic [7:0]  mx;
        logic [15:0] v;
        for (int i = 0; i < 3; i++) begin
            mx = {4'h0, (i == 0) ? SLOT_MAX_BASE : (i == 1) ? SLOT_MAX_OPT1 : SLOT_MAX_OPT2};
            v  = 16'hC300 + 16'(i);
            @(posedge core_clk);
            mem_option <= i[1:0];
            cur_setup  <= v;
            op(CMD_SAV, mx, 1);
            chk("sav_ok", cmd_rejected, 1'b0);
            @(posedge core_clk);
            cur_setup <= ~v;
            op(CMD_SAV, mx + 8'h01, 1);
            chk("sav_bad", cmd_rejected, 1'b1);
            op(CMD_RCL, mx + 8'h01, 1);
            chk("rcl_bad", cmd_rejected, 1'b1);
            wait_neg(2);
            chk("rcl_bad_load", setup_load, 1'b0);
            op(CMD_RCL, mx, 3);
            chk("rcl_load", setup_load, 1'b1);
            chk("rcl_data", setup_out, v);
        end
    endtask

    task automatic t_recall_err();
        @(posedge core_clk);
        mem_option <= MEM_OPT2;
        cur_setup  <= 16'h3C5A;
        op(CMD_SAV, 8'h03, 1);
        srqe_host_model_inst.issue(CMD_RCL, 8'h03);
        mem_fault <= 1'b1;
        repeat (2) @(posedge core_clk);
        mem_fault <= 1'b0;
        wait_neg(1);
        chk("err_ready", cmd_ready, 1'b1);
        chk("err_flag", recall_error, 1'b1);
        chk("err_load", setup_load, 1'b1);
        chk("err_data", setup_out, PRESET_SETUP);
        op(CMD_RCL, 8'h03, 3);
        chk("err_reload", setup_out, PRESET_SETUP);
    endtask

    task automatic t_reset_cmd();
        srqe_host_model_inst.write_mask(8'h30);
        op(CMD_RST, 8'h00, 1);
        chk("rst_load", setup_load, 1'b1);
        chk("rst_data", setup_out, RESET_SETUP);
        chk("rst_cancel", cancel_pending, 1'b1);
        chk("rst_opc", drop_opc, 1'b1);
        chk("rst_mask", service_request_mask, 8'h30);
        // codes above the mask query are refused
        op(3'h6, 8'h00, 1);
        chk("bad_code", cmd_rejected, 1'b1);
        chk("bad_rsp", rsp_valid, 1'b0);
    endtask

    task automatic t_mask();
        logic [7:0] w [9] = '{8'h00, 8'h01, 8'h04, 8'h08, 8'h10, 8'h20, 8'h80, 8'hFF, 8'h30};
        foreach (w[k]) begin
            srqe_host_model_inst.write_mask(w[k]);
            op(CMD_SRE_RD, 8'h00, 1);
            chk("sre_v", rsp_valid, 1'b1);
            chk("sre_q", rsp_field0, w[k]);
            chk("sre_q1", rsp_field1, 8'h00);
        end
        // unused bits 1 and 6 must never request service
        for (int b = 0; b < 8; b++) begin
            srqe_host_model_inst.write_mask(8'h01 << b);
            @(posedge core_clk);
            status_byte <= 8'h01 << b;
            wait_neg(2);
            chk("srq_on", srq, SRE_USED[b]);
            chk("mss_on", mss_bit, SRE_USED[b]);
            @(posedge core_clk);
            status_byte <= ~(8'h01 << b);
            wait_neg(2);
            chk("srq_off", srq, 1'b0);
        end
    endtask

    // =========================================================
    // main sequence and watchdog
    initial begin
        do_reset();
        t_power_up();
        t_option();
        t_slots();
        t_recall_err();
        t_reset_cmd();
        t_mask();
        do_reset();
        wait_neg(1);
        chk("mask_rst", service_request_mask, SRE_RESET);
        chk("take", wait_fail, 1'b0);
        print_verdict();
    end

    initial begin
        #(50 * 5000);
        err_total++;
        print_verdict();
    end
endmodule // srqe_core_tb
